// ---- rtl/ebr_pkg.sv ----
// Purpose: Shared constants and types for the external bus READY wait controller.
// Assumes: 25 MHz system clock, which is also the bus reference clock.
// Notes:   Register map, fields, reset values and phase codes.
//
// Contract
// - Read data latched on edge raising read strobe
// - Late address change never alters captured data
// - External READY may lengthen the bus cycle
// - READY polarity selectable, sampled level interpreted
// - Sync READY sampled without synchroniser, partner-synchronous
// - Async READY synchronised, costs one wait minimum
// - First sampling point follows programmed phase lengths
// - Inactive READY inserts one wait, then resamples
// - Active READY ends the running cycle
// - Sync and async modes sample at different points
// - READY ignored until access phase waits elapse
// - Five phases: address, command, data, access, hold
// - Access phase lasts 1 to 32 clocks
package ebr_pkg;

    // Bus widths
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 16;
    localparam int REG_AW  = 4;
    localparam int REG_DW  = 32;
    localparam int WIN_W   = 8;
    localparam int CNT_W   = 5;

    // Clock
    localparam int CLK_PERIOD_NS = 40;

    // Register offsets
    localparam logic [REG_AW-1:0] REG_TIMING = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h4;
    localparam logic [REG_AW-1:0] REG_WAITS  = 4'h8;

    // Timing register fields: position and width
    localparam int F_AB_LEN    = 0;
    localparam int W_AB_LEN    = 1;
    localparam int F_CMD_DLY   = 1;
    localparam int W_CMD_DLY   = 2;
    localparam int F_DSETUP    = 3;
    localparam int F_ACCESS    = 4;
    localparam int W_ACCESS    = 5;
    localparam int F_HOLD      = 9;
    localparam int W_HOLD      = 2;
    localparam int F_WIN_EXT   = 11;
    localparam int W_WIN_EXT   = 2;
    localparam int F_RDY_EN    = 13;
    localparam int F_RDY_POL   = 14;
    localparam int F_RDY_ASYNC = 15;
    localparam int F_REFCLK_EN = 16;

    // Reset value and writable bits of the timing register
    localparam logic [REG_DW-1:0] TIMING_RST  = 32'h0000_0000;
    localparam logic [REG_DW-1:0] TIMING_MASK = 32'h0001_FFFF;

    // Status register fields
    localparam int S_BUSY      = 0;
    localparam int S_STATE     = 1;
    localparam int S_READY     = 4;
    localparam int S_WAITS     = 8;

    // Bus cycle phases
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_CMD    = 3'h2,
        ST_DSET   = 3'h3,
        ST_ACCESS = 3'h4,
        ST_RDYW   = 3'h5,
        ST_HOLD   = 3'h6
    } ebr_state_t;

endpackage

// ---- rtl/ebr_ready_sampler.sv ----
// Purpose: Samples the READY pin on two paths and applies the polarity choice.
// Assumes: Sync path needs READY driven on the bus clock.
// Notes:   Async path: two stages, the first feeds only the second.
`timescale 1ns/100ps
module ebr_ready_sampler (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    // Pin and mode
    input  wire logic ready_pin_i,
    input  wire logic active_high_i,
    input  wire logic async_i,
    // Interpreted level
    output logic      ready_act_o
);

    logic sync_q;
    logic async_q1;
    logic async_q2;
    logic raw;

    ////////////////////////////////
    // Single capture for sync mode, two-stage chain for async mode
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_q   <= 1'b0;
            async_q1 <= 1'b0;
            async_q2 <= 1'b0;
        end else if (ce_i) begin
            sync_q   <= ready_pin_i;
            async_q1 <= ready_pin_i;
            async_q2 <= async_q1;
        end
    end

    ////////////////////////////////
    // Path choice, then polarity; low-active READY is inverted here once
    always_comb begin
        raw         = async_i ? async_q2 : sync_q;
        ready_act_o = active_high_i ? raw : ~raw;
    end

endmodule

// ---- rtl/ebr_ctrl.sv ----
// Purpose: Runs five-phase external bus cycles with READY-controlled access stretching.
// Assumes: Demultiplexed bus; clk_i doubles as the reference clock.
// Notes:   Timing is copied at cycle start; reprogramming hits the next cycle, except READY polarity, path and reference clock enable, which act at once.
`timescale 1ns/100ps
module ebr_ctrl #(
    parameter int ADDR_W = ebr_pkg::ADDR_W,
    parameter int DATA_W = ebr_pkg::DATA_W
) (
    // Clock, reset, enable
    input  wire logic                      clk_i,
    input  wire logic                      srst_i,
    input  wire logic                      ce_i,
    // Register port
    input  wire logic [ebr_pkg::REG_AW-1:0] reg_addr_i,
    input  wire logic [ebr_pkg::REG_DW-1:0] reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [ebr_pkg::REG_DW-1:0] reg_rdata_o,
    // Internal request side
    input  wire logic                      req_valid_i,
    input  wire logic                      req_write_i,
    input  wire logic [ADDR_W-1:0]         req_addr_i,
    input  wire logic [DATA_W-1:0]         req_wdata_i,
    output logic                           req_ready_o,
    output logic                           done_o,
    output logic      [DATA_W-1:0]         rdata_o,
    // External bus pins
    output logic      [ADDR_W-1:0]         ebus_addr_o,
    output logic                           ebus_cs_n_o,
    output logic                           ebus_rd_n_o,
    output logic                           ebus_wr_n_o,
    input  wire logic [DATA_W-1:0]         ebus_data_i,
    output logic      [DATA_W-1:0]         ebus_data_o,
    output logic                           ebus_data_oe_o,
    input  wire logic                      ebus_ready_i,
    output logic                           bus_reference_clock_en_o
);

    localparam int CW = ebr_pkg::CNT_W;
    localparam int WW = ebr_pkg::WIN_W;

    ////////////////////////////////
    // State types

    typedef struct packed {
        ebr_pkg::ebr_state_t st;
        logic [CW-1:0]       cnt;
    } ebr_step_t;

    typedef struct packed {
        ebr_pkg::ebr_state_t          st;
        logic [CW-1:0]                cnt;
        logic [ebr_pkg::REG_DW-1:0]   cfg;
        logic [ebr_pkg::REG_DW-1:0]   cyc;
        logic                         is_write;
        logic [ADDR_W-1:0]            addr;
        logic [DATA_W-1:0]            wdata;
        logic [WW-1:0]                last_win;
        logic                         win_valid;
        logic                         req_ready;
        logic                         done;
        logic [DATA_W-1:0]            rdata;
        logic                         rd_n;
        logic                         wr_n;
        logic                         cs_n;
        logic                         data_oe;
        logic [ebr_pkg::REG_DW-1:0]   reg_rdata;
        logic [7:0]                   last_waits;
        logic [15:0]                  total_waits;
    } ebr_regs_t;

    ebr_regs_t r;
    ebr_regs_t next_r;

    ////////////////////////////////
    // Decoded fields of the per-cycle timing copy

    localparam int W_CMD_LEN = ebr_pkg::W_CMD_DLY;
    logic [W_CMD_LEN-1:0] cmd_len;
    logic                 dset_len;
    logic [CW-1:0]        acc_len;
    logic [1:0]           hold_len;
    logic                 rdy_en;
    logic                 rdy_async;
    logic                 ready_act;
    logic                 win_chg;
    logic [CW-1:0]        addr_len;
    logic [7:0]           waits_inc;
    logic [15:0]          total_inc;

    always_comb begin
        cmd_len   = r.cyc[ebr_pkg::F_CMD_DLY +: ebr_pkg::W_CMD_DLY];
        dset_len  = r.cyc[ebr_pkg::F_DSETUP];
        acc_len   = r.cyc[ebr_pkg::F_ACCESS +: ebr_pkg::W_ACCESS];   // Holds length minus one
        hold_len  = r.cyc[ebr_pkg::F_HOLD +: ebr_pkg::W_HOLD];
        rdy_en    = r.cyc[ebr_pkg::F_RDY_EN];
        rdy_async = r.cyc[ebr_pkg::F_RDY_ASYNC];
    end

    ////////////////////////////////
    // READY sampling; steered by the live config so the
    // synchroniser is filled before a cycle starts

    ebr_ready_sampler u_ready (
        .clk_i         (clk_i),
        .srst_i        (srst_i),
        .ce_i          (ce_i),
        .ready_pin_i   (ebus_ready_i),
        .active_high_i (r.cfg[ebr_pkg::F_RDY_POL]),
        .async_i       (r.cfg[ebr_pkg::F_RDY_ASYNC]),
        .ready_act_o   (ready_act)
    );

    ////////////////////////////////
    // Address phase length, plus the extension on a window change

    always_comb begin
        win_chg  = !r.win_valid || (req_addr_i[ADDR_W-1 -: WW] != r.last_win);
        addr_len = CW'(r.cfg[ebr_pkg::F_AB_LEN]);
        if (win_chg) begin
            addr_len = addr_len + CW'(r.cfg[ebr_pkg::F_WIN_EXT +: ebr_pkg::W_WIN_EXT]);
        end
    end

    ////////////////////////////////
    // Saturating wait counters, so a stuck READY cannot wrap the statistics

    always_comb begin
        waits_inc = (r.last_waits == 8'hFF) ? r.last_waits : r.last_waits + 8'h01;
        total_inc = (r.total_waits == 16'hFFFF) ? r.total_waits : r.total_waits + 16'h0001;
    end

    ////////////////////////////////
    // Phase sequencing helpers; empty phases are skipped in the same edge

    function automatic ebr_step_t enter_access(input logic [CW-1:0] len);
        ebr_step_t s;
        s.st  = ebr_pkg::ST_ACCESS;
        s.cnt = len;
        return s;
    endfunction

    function automatic ebr_step_t after_cmd(input logic d, input logic [CW-1:0] len);
        ebr_step_t s;
        if (d) begin
            s.st  = ebr_pkg::ST_DSET;
            s.cnt = '0;
        end else begin
            s = enter_access(len);
        end
        return s;
    endfunction

    function automatic ebr_step_t after_addr(input logic [1:0] c, input logic d,
                                             input logic [CW-1:0] len);
        ebr_step_t s;
        if (c != 2'h0) begin
            s.st  = ebr_pkg::ST_CMD;
            s.cnt = CW'(c) - CW'(1);
        end else begin
            s = after_cmd(d, len);
        end
        return s;
    endfunction

    function automatic ebr_step_t end_access(input logic [1:0] f);
        ebr_step_t s;
        if (f != 2'h0) begin
            s.st  = ebr_pkg::ST_HOLD;
            s.cnt = CW'(f) - CW'(1);
        end else begin
            s.st  = ebr_pkg::ST_IDLE;
            s.cnt = '0;
        end
        return s;
    endfunction

    ////////////////////////////////
    // Next-state logic for the whole block

    always_comb begin
        ebr_step_t step;
        logic      finish;
        step   = '{st: r.st, cnt: r.cnt};
        finish = 1'b0;
        next_r = r;

        // Register writes
        if (reg_wr_i && reg_addr_i == ebr_pkg::REG_TIMING) begin
            next_r.cfg = reg_wdata_i & ebr_pkg::TIMING_MASK;
        end
        if (reg_wr_i && reg_addr_i == ebr_pkg::REG_WAITS) begin
            next_r.total_waits = '0;
        end

        // Phase sequencing
        unique case (r.st)
            ebr_pkg::ST_IDLE: begin
                if (req_valid_i && r.req_ready) begin
                    step.st          = ebr_pkg::ST_ADDR;
                    step.cnt         = addr_len;
                    next_r.cyc       = r.cfg;
                    next_r.is_write  = req_write_i;
                    next_r.addr      = req_addr_i;
                    next_r.wdata     = req_wdata_i;
                    next_r.last_win  = req_addr_i[ADDR_W-1 -: WW];
                    next_r.win_valid = 1'b1;
                    next_r.last_waits = '0;
                end
            end
            ebr_pkg::ST_ADDR: begin
                if (r.cnt != '0) begin
                    step.cnt = r.cnt - CW'(1);
                end else begin
                    step = after_addr(cmd_len, dset_len, acc_len);
                end
            end
            ebr_pkg::ST_CMD: begin
                if (r.cnt != '0) begin
                    step.cnt = r.cnt - CW'(1);
                end else begin
                    step = after_cmd(dset_len, acc_len);
                end
            end
            ebr_pkg::ST_DSET: begin
                step = enter_access(acc_len);
            end
            ebr_pkg::ST_ACCESS: begin
                if (r.cnt != '0) begin
                    step.cnt = r.cnt - CW'(1);
                end else if (!rdy_en) begin
                    finish = 1'b1;
                end else if (rdy_async) begin
                    step.st  = ebr_pkg::ST_RDYW;
                    step.cnt = '0;
                end else if (ready_act) begin
                    finish = 1'b1;
                end else begin
                    step.st  = ebr_pkg::ST_RDYW;
                    step.cnt = '0;
                end
            end
            ebr_pkg::ST_RDYW: begin
                if (ready_act) begin
                    finish = 1'b1;
                end else begin
                    step.st = ebr_pkg::ST_RDYW;
                end
            end
            ebr_pkg::ST_HOLD: begin
                if (r.cnt != '0) begin
                    step.cnt = r.cnt - CW'(1);
                end else begin
                    step.st  = ebr_pkg::ST_IDLE;
                    step.cnt = '0;
                end
            end
            default: begin
                step.st  = ebr_pkg::ST_IDLE;
                step.cnt = '0;
            end
        endcase

        // End of access: the strobe rises and read data are taken on this same edge
        if (finish) begin
            step = end_access(hold_len);
            if (!r.is_write) begin
                next_r.rdata = ebus_data_i;
            end
        end

        // Wait statistics; counting wins over a clear in the same cycle
        if (r.st == ebr_pkg::ST_RDYW) begin
            next_r.last_waits  = waits_inc;
            next_r.total_waits = total_inc;
        end

        next_r.st  = step.st;
        next_r.cnt = step.cnt;

        // Pin levels follow the phase entered at this edge
        next_r.cs_n    = (step.st == ebr_pkg::ST_IDLE);
        next_r.rd_n    = !(!next_r.is_write && (step.st == ebr_pkg::ST_ACCESS ||
                                               step.st == ebr_pkg::ST_RDYW));
        next_r.wr_n    = !(next_r.is_write && (step.st == ebr_pkg::ST_ACCESS ||
                                              step.st == ebr_pkg::ST_RDYW));
        next_r.data_oe = next_r.is_write && (step.st == ebr_pkg::ST_DSET ||
                                             step.st == ebr_pkg::ST_ACCESS ||
                                             step.st == ebr_pkg::ST_RDYW ||
                                             step.st == ebr_pkg::ST_HOLD);
        next_r.req_ready = (step.st == ebr_pkg::ST_IDLE);
        next_r.done      = (step.st == ebr_pkg::ST_IDLE) && (r.st != ebr_pkg::ST_IDLE);

        // Register read data stand for exactly one cycle
        next_r.reg_rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ebr_pkg::REG_TIMING: begin
                    next_r.reg_rdata = r.cfg;
                end
                ebr_pkg::REG_STATUS: begin
                    next_r.reg_rdata[ebr_pkg::S_BUSY]        = (r.st != ebr_pkg::ST_IDLE);
                    next_r.reg_rdata[ebr_pkg::S_STATE +: 3]  = r.st;
                    next_r.reg_rdata[ebr_pkg::S_READY]       = ready_act;
                    next_r.reg_rdata[ebr_pkg::S_WAITS +: 8]  = r.last_waits;
                end
                ebr_pkg::REG_WAITS: begin
                    next_r.reg_rdata[15:0] = r.total_waits;
                end
                default: begin
                    next_r.reg_rdata = '0;                      // Unmapped reads as zero
                end
            endcase
        end
    end

    ////////////////////////////////
    // State register; a low clock enable freezes everything

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r             <= '0;
            r.st          <= ebr_pkg::ST_IDLE;
            r.cfg         <= ebr_pkg::TIMING_RST;
            r.cyc         <= ebr_pkg::TIMING_RST;
            r.req_ready   <= 1'b1;
            r.rd_n        <= 1'b1;
            r.wr_n        <= 1'b1;
            r.cs_n        <= 1'b1;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    ////////////////////////////////
    // Outputs, all taken straight from the state register

    always_comb begin
        reg_rdata_o              = r.reg_rdata;
        req_ready_o              = r.req_ready;
        done_o                   = r.done;
        rdata_o                  = r.rdata;
        ebus_addr_o              = r.addr;
        ebus_cs_n_o              = r.cs_n;
        ebus_rd_n_o              = r.rd_n;
        ebus_wr_n_o              = r.wr_n;
        ebus_data_o              = r.wdata;
        ebus_data_oe_o           = r.data_oe;
        bus_reference_clock_en_o = r.cfg[ebr_pkg::F_REFCLK_EN];
    end

endmodule

// ---- testbench/ebr_ctrl_assertions.sv ----
// Purpose: Port-level checks of the READY wait controller.
// Assumes: TIMING is written only while the bus is idle.
// Notes:   Keeps a shadow of TIMING taken from register writes.
`timescale 1ns/100ps
module ebr_ctrl_assertions #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    // Clock and register writes
    input wire logic                       clk_i,
    input wire logic                       srst_i,
    input wire logic                       ce_i,
    input wire logic [ebr_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [ebr_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    // Request side and bus pins
    input wire logic                       done_o,
    input wire logic [DATA_W-1:0]          rdata_o,
    input wire logic [ADDR_W-1:0]          ebus_addr_o,
    input wire logic                       ebus_cs_n_o,
    input wire logic                       ebus_rd_n_o,
    input wire logic                       ebus_wr_n_o,
    input wire logic                       ebus_data_oe_o,
    input wire logic [DATA_W-1:0]          ebus_data_i,
    input wire logic                       ebus_ready_i
);
    logic [31:0] cfg;
    logic [5:0]  low_cnt;
    logic [5:0]  acc_len;
    logic        strobe;
    logic        ract;
    logic        en;
    logic        asy;
    ////////////////////////////////////////
    // Shadow config and strobe length; ready level read through polarity
    assign strobe  = !ebus_rd_n_o || !ebus_wr_n_o;
    assign ract    = ebus_ready_i == cfg[ebr_pkg::F_RDY_POL];
    assign en      = cfg[ebr_pkg::F_RDY_EN];
    assign asy     = cfg[ebr_pkg::F_RDY_ASYNC];
    assign acc_len = {1'b0, cfg[ebr_pkg::F_ACCESS +: ebr_pkg::W_ACCESS]} + 6'h01;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg     <= 32'h0000_0000;
            low_cnt <= 6'h00;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == ebr_pkg::REG_TIMING)
                cfg <= reg_wdata_i & ebr_pkg::TIMING_MASK;
            low_cnt <= strobe ? low_cnt + 6'h01 : 6'h00;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_STROBE_IN_CS: assert property (strobe |-> !ebus_cs_n_o)
        else $error("strobe outside chip select");
    AST_ONE_STROBE: assert property (!(!ebus_rd_n_o && !ebus_wr_n_o))
        else $error("both strobes low");
    AST_ACCESS_MIN: assert property ($fell(strobe) |-> low_cnt >= acc_len)
        else $error("access phase cut short");
    AST_NO_READY: assert property ($fell(strobe) && !en |-> low_cnt == acc_len)
        else $error("wrong access length without ready");
    AST_SYNC_END: assert property ($fell(strobe) && en && !asy |-> $past(ract, 2))
        else $error("sync cycle ended without ready");
    AST_SYNC_WAIT: assert property ($fell(strobe) && en && !asy && low_cnt > acc_len
        |-> !$past(ract, 3))
        else $error("wait inserted with ready active");
    AST_ASYNC_MIN: assert property ($fell(strobe) && en && asy |-> low_cnt > acc_len)
        else $error("async cycle without wait");
    AST_ASYNC_END: assert property ($fell(strobe) && en && asy |-> $past(ract, 3))
        else $error("async cycle ended without ready");
    AST_RDATA: assert property ($rose(ebus_rd_n_o) |-> rdata_o == $past(ebus_data_i))
        else $error("read data not taken at strobe end");
    AST_ADDR_STABLE: assert property (!ebus_cs_n_o && !$past(ebus_cs_n_o)
        |-> $stable(ebus_addr_o))
        else $error("address moved in cycle");
    AST_DONE_END: assert property (done_o |-> ebus_cs_n_o ##1 !done_o)
        else $error("done while bus active");
    AST_OE_WRITE: assert property (!ebus_wr_n_o |-> ebus_data_oe_o)
        else $error("write strobe without data drive");
endmodule

bind ebr_ctrl ebr_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_ebr_chk (
    .clk_i, .srst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .done_o, .rdata_o,
    .ebus_addr_o, .ebus_cs_n_o, .ebus_rd_n_o, .ebus_wr_n_o, .ebus_data_oe_o,
    .ebus_data_i, .ebus_ready_i);

// ---- testbench/ebr_ext_mem_model.sv ----
// Purpose: External memory that stretches cycles with READY.
// Assumes: Sync mode drives READY from bus-clocked pins.
// Notes:   Read pins show inverted data outside the read strobe.
`timescale 1ns/100ps
module ebr_ext_mem_model (
    // Bus pins
    input  wire logic        clk_i,
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    output logic             ready_o,
    // Behaviour
    input  wire logic        act_high_i,
    input  wire logic        async_i,
    input  wire logic [7:0]  delay_i
);
    logic [15:0] mem [16];
    logic [7:0]  cnt = 8'h00;
    logic        strb;
    logic        act;
    logic        lvl;
    logic        lvl_late;
    ////////////////////////////////////////
    // Ready follows the strobe after delay_i clocks, or chip select when delay_i is zero
    assign strb = !rd_n_i || !wr_n_i;
    assign act  = !cs_n_i && (delay_i == 8'h00 || (strb && cnt >= delay_i));
    assign lvl  = act_high_i ? act : !act;
    assign #17 lvl_late = lvl;
    assign ready_o = async_i ? lvl_late : lvl;
    assign rdata_o = !rd_n_i ? mem[addr_i] : ~mem[addr_i];
    // Strobe age and write storage; the last write cycle wins
    always @(posedge clk_i) begin
        cnt <= strb ? cnt + 8'h01 : 8'h00;
        if (!wr_n_i)
            mem[addr_i] <= wdata_i;
    end
endmodule

// ---- testbench/test_ext_bus_ready_wait_control.sv ----
// Purpose: Self-checking bench for the READY wait controller.
// Assumes: One clock; the memory model sits on the bus pins.
// Notes:   Each row is run as a write then a read.
`timescale 1ns/100ps
module test_ext_bus_ready_wait_control;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [23:0] req_addr_i = 24'h0;
    logic [15:0] req_wdata_i = 16'h0;
    logic [31:0] reg_rdata_o;
    logic [23:0] ebus_addr_o;
    logic [15:0] rdata_o, ebus_data_i, ebus_data_o;
    logic        req_ready_o, done_o, ebus_cs_n_o, ebus_rd_n_o, ebus_wr_n_o;
    logic        ebus_data_oe_o, ebus_ready_i, rce;
    logic        pol = 1'b1;
    logic        asy = 1'b0;
    logic [7:0]  dly = 8'h00;
    int fail_count = 0, n_checks = 0, cyc = 0, cs_len = 0, st_len = 0, wsum = 0;
    // Rows: access, cmd, hold, ab, ready en, polarity, async, partner delay
    int tab [8][8] = '{'{1, 0, 0, 0, 1, 1, 0, 0}, '{1, 0, 0, 0, 1, 1, 0, 3},
                       '{4, 1, 0, 0, 1, 0, 0, 1}, '{4, 0, 1, 0, 1, 1, 1, 0},
                       '{2, 0, 0, 0, 1, 0, 1, 2}, '{3, 0, 0, 0, 0, 1, 0, 99},
                       '{32, 3, 3, 1, 1, 1, 0, 0}, '{1, 2, 0, 1, 1, 0, 1, 4}};

    always #20 clk_i = ~clk_i;

    ebr_ctrl DUT (.clk_i, .srst_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
        .req_ready_o, .done_o, .rdata_o, .ebus_addr_o, .ebus_cs_n_o, .ebus_rd_n_o,
        .ebus_wr_n_o, .ebus_data_i, .ebus_data_o, .ebus_data_oe_o, .ebus_ready_i,
        .bus_reference_clock_en_o(rce));
    ebr_ext_mem_model u_mem (.clk_i, .cs_n_i(ebus_cs_n_o), .rd_n_i(ebus_rd_n_o),
        .wr_n_i(ebus_wr_n_o), .addr_i(ebus_addr_o[3:0]), .wdata_i(ebus_data_o),
        .rdata_o(ebus_data_i), .ready_o(ebus_ready_i), .act_high_i(pol), .async_i(asy),
        .delay_i(dly));

    ////////////////////////////////////////
    // Cycle counter, chip select and strobe lengths, hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (!ebus_cs_n_o) cs_len++;
        if (!ebus_rd_n_o || !ebus_wr_n_o) st_len++;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Data stand one cycle after the strobe
    task automatic rr(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Strobe length: sync sees READY one edge late, async two plus a wait
    function automatic int exp_len(int e, int en, int a, int k);
        if (en == 0) return e;
        if (a != 0) return (k == 0) ? e + 1 : ((k + 3 > e + 1) ? k + 3 : e + 1);
        return (k == 0) ? e : ((k + 2 > e) ? k + 2 : e);
    endfunction

    task automatic bus(input logic wr, input logic [15:0] d, input int acc, input int exst,
                       input int excs);
        logic [31:0] v;
        int n;
        @(posedge clk_i);
        req_valid_i <= 1'b1; req_write_i <= wr; req_addr_i <= 24'h000005; req_wdata_i <= d;
        cs_len = 0;
        st_len = 0;
        n = 0;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        while (done_o !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1 n++;
        end
        check(n < 200, 1);
        check(st_len, exst);
        check(cs_len, excs);
        check({req_ready_o, rce, ebus_addr_o}, {2'h3, 24'h000005});
        if (!wr) check(rdata_o, d);
        rr(ebr_pkg::REG_STATUS, v);
        check(v[15:8], exst - acc);
        wsum += exst - acc;
    endtask

    ////////////////////////////////////////
    initial begin
        logic [31:0] v;
        int e;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        rr(ebr_pkg::REG_TIMING, v); check(v, ebr_pkg::TIMING_RST);
        rw(ebr_pkg::REG_TIMING, 32'hFFFF_FFFF);
        rr(ebr_pkg::REG_TIMING, v); check(v, ebr_pkg::TIMING_MASK);
        rr(4'hC, v); check(v, 32'h0);
        rw(ebr_pkg::REG_STATUS, 32'hFFFF_FFFF);
        rr(ebr_pkg::REG_STATUS, v); check(v[3:0], 0);
        rw(ebr_pkg::REG_WAITS, 32'h0);
        $display("test registers finished");
        foreach (tab[r]) begin
            rw(ebr_pkg::REG_TIMING, ((tab[r][0] - 1) << ebr_pkg::F_ACCESS) | (tab[r][1] << 1)
                | (tab[r][2] << ebr_pkg::F_HOLD) | tab[r][3] | (tab[r][4] << ebr_pkg::F_RDY_EN)
                | (tab[r][5] << ebr_pkg::F_RDY_POL) | (tab[r][6] << ebr_pkg::F_RDY_ASYNC)
                | 32'h0001_0000);
            pol <= tab[r][5][0]; asy <= tab[r][6][0]; dly <= tab[r][7][7:0];
            e = exp_len(tab[r][0], tab[r][4], tab[r][6], tab[r][7]);
            bus(1'b1, 16'hA5C0 ^ 16'(r), tab[r][0], e, 1 + tab[r][3] + tab[r][1] + e + tab[r][2]);
            bus(1'b0, 16'hA5C0 ^ 16'(r), tab[r][0], e, 1 + tab[r][3] + tab[r][1] + e + tab[r][2]);
            $display("test row %0d finished", r);
        end
        rr(ebr_pkg::REG_WAITS, v); check(v, wsum);
        conclude();
    end
endmodule
